// [pkg/urap_pkg.sv]
// constants and types of the serial register access port
//
// Summary of operation
// - each character is a start bit, eight data bits, a stop bit, no parity.
// - the port resets to 9600 bit/s, then takes the rate chosen by baud_sel while idle.
// - the port also runs at 115200, 921600 and 3000000 bit/s.
// - every command and every response is exactly five bytes long.
// - a gap of more than one second between bytes drops the partial command.
// - byte one is flag and 7-bit address; four data bytes follow, MSB first.
// - a set flag writes the 32-bit payload, except at 0x00 where it is dropped; a clear flag reads and ignores it.
// - a read answers with the address byte, then the register word, MSB first.
// - a write answers with flag, address and data laid out as the command.
// - a selector written at 0x01 chooses the id word read back at 0x00.
// - register accesses other than 0x00 and 0x01 go through the shared arbiter.
`default_nettype none
package urap_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned BAUD_MID = 115200;
  localparam int unsigned BAUD_FAST = 921600;
  localparam int unsigned BAUD_MAX = 3_000_000;
  // bit periods rounded to the nearest clock count
  localparam int unsigned DIV_DEFAULT =
    (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
  localparam logic [12:0] DIV_MID = 13'((CLK_HZ + BAUD_MID / 2) / BAUD_MID);
  localparam logic [12:0] DIV_FAST = 13'((CLK_HZ + BAUD_FAST / 2) / BAUD_FAST);
  localparam logic [12:0] DIV_MAX = 13'((CLK_HZ + BAUD_MAX / 2) / BAUD_MAX);
  // rate select codes
  localparam logic [1:0] RATE_DEFAULT = 2'h0;
  localparam logic [1:0] RATE_MID = 2'h1;
  localparam logic [1:0] RATE_FAST = 2'h2;
  localparam logic [1:0] RATE_MAX = 2'h3;
  // inactivity limit
  localparam int unsigned TIMEOUT_MS = 1000;
  localparam int unsigned TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  // framing
  localparam logic [3:0] STOP_BIT_IDX = 4'h9;
  localparam logic [2:0] LAST_BYTE_IDX = 3'h4;
  localparam logic [2:0] DGRAM_BYTES = 3'h5;
  // locally held addresses
  localparam logic [6:0] ADDR_ID_VALUE = 7'h00;
  localparam logic [6:0] ADDR_ID_SEL = 7'h01;
  localparam logic [31:0] ID_SEL_RESET = 32'h0000_0000;

  typedef struct packed {
    logic write_not_read_flag;
    logic [6:0] addr;
    logic [31:0] data;
  } urap_dgram_type;

  typedef struct packed {
    logic valid;
    logic we;
    logic [6:0] addr;
    logic [31:0] wdata;
  } urap_req_type;

  typedef enum logic [1:0] {
    ST_COLLECT,
    ST_ACCESS,
    ST_WAIT_RD,
    ST_RESPOND
  } urap_state_type;
endpackage : urap_pkg
`default_nettype wire

// [rtl/urap_top.sv]
// serial register access port: uart, five-byte protocol, arbiter request
`default_nettype none
module urap_top #(
  parameter int unsigned DIV_DEFAULT_CYC = urap_pkg::DIV_DEFAULT,
  parameter int unsigned TIMEOUT_CYC = urap_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // line rate choice, taken while the port is idle
  input wire logic [1:0] baud_sel,
  // serial line
  input wire logic reg_port_serial_in,
  output logic reg_port_serial_out,
  // arbiter port
  output urap_pkg::urap_req_type arb_req,
  input wire logic arb_gnt,
  input wire logic arb_rvalid,
  input wire logic [31:0] arb_rdata,
  // chip id selection
  output logic [31:0] chip_id_selector,
  input wire logic [31:0] chip_id_value
);
  localparam logic [12:0] DIV0 = 13'(DIV_DEFAULT_CYC);
  localparam logic [25:0] TO_LAST = 26'(TIMEOUT_CYC - 1);

  logic [1:0] rate_q;
  logic rx_busy_q, rx_prev_q, rx_valid_q;
  logic [12:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic tx_busy_q, tx_line_q;
  logic [12:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;
  urap_pkg::urap_state_type st_q;
  urap_pkg::urap_dgram_type dg_q, resp_q;
  logic [2:0] byte_cnt_q, tx_idx_q;
  logic [25:0] to_q;
  logic [31:0] sel_q;

  // bit period for the chosen rate
  logic [12:0] div_w;
  assign div_w = (rate_q == urap_pkg::RATE_MID) ? urap_pkg::DIV_MID :
                 (rate_q == urap_pkg::RATE_FAST) ? urap_pkg::DIV_FAST :
                 (rate_q == urap_pkg::RATE_MAX) ? urap_pkg::DIV_MAX : DIV0;
  logic [12:0] half_w;
  assign half_w = {1'b0, div_w[12:1]};
  logic port_idle_w;
  assign port_idle_w = !rx_busy_q && !tx_busy_q && st_q == urap_pkg::ST_COLLECT
                       && byte_cnt_q == 3'h0;

  // rate only changes between commands so no character is cut in half
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_q <= urap_pkg::RATE_DEFAULT;
    end else if (port_idle_w) begin
      rate_q <= baud_sel;
    end
  end

  // receiver: falling edge, middle of start bit, then one sample per bit
  logic rx_fall_w, rx_tick_w;
  assign rx_fall_w = !rx_busy_q && rx_prev_q && !reg_port_serial_in;
  assign rx_tick_w = rx_busy_q && rx_cnt_q == 13'h0000;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_busy_q <= 1'b0;
      rx_prev_q <= 1'b1;
      rx_valid_q <= 1'b0;
      rx_cnt_q <= 13'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
    end else begin
      rx_prev_q <= reg_port_serial_in;
      rx_valid_q <= 1'b0;
      if (rx_fall_w) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q <= half_w;
        rx_bit_q <= 4'h0;
      end else if (rx_tick_w) begin
        rx_cnt_q <= div_w - 13'h0001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && reg_port_serial_in) begin
          rx_busy_q <= 1'b0; // glitch, not a start bit
        end else if (rx_bit_q == urap_pkg::STOP_BIT_IDX) begin
          rx_busy_q <= 1'b0;
          rx_valid_q <= reg_port_serial_in; // bad stop bit drops byte
        end else if (rx_bit_q != 4'h0) begin
          rx_sh_q <= {reg_port_serial_in, rx_sh_q[7:1]}; // lsb first
        end
      end else if (rx_busy_q) begin
        rx_cnt_q <= rx_cnt_q - 13'h0001;
      end
    end
  end

  // transmitter: start bit, eight data bits, stop bit
  logic tx_load_w, tx_tick_w;
  assign tx_load_w = st_q == urap_pkg::ST_RESPOND && !tx_busy_q
                     && tx_idx_q != urap_pkg::DGRAM_BYTES;
  assign tx_tick_w = tx_busy_q && tx_cnt_q == 13'h0000;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_busy_q <= 1'b0;
      tx_line_q <= 1'b1;
      tx_cnt_q <= 13'h0000;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h1FF;
    end else if (tx_load_w) begin
      tx_busy_q <= 1'b1;
      tx_line_q <= 1'b0; // start bit
      tx_sh_q <= {1'b1, resp_q[39:32]}; // stop bit above the data
      tx_cnt_q <= div_w - 13'h0001;
      tx_bit_q <= 4'h0;
    end else if (tx_tick_w) begin
      tx_cnt_q <= div_w - 13'h0001;
      if (tx_bit_q == urap_pkg::STOP_BIT_IDX) begin
        tx_busy_q <= 1'b0;
      end else begin
        tx_line_q <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[8:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
      end
    end else if (tx_busy_q) begin
      tx_cnt_q <= tx_cnt_q - 13'h0001;
    end
  end
  assign reg_port_serial_out = tx_line_q;

  // decode of the collected command
  logic local_w, timeout_w;
  assign local_w = dg_q.addr == urap_pkg::ADDR_ID_VALUE
                   || dg_q.addr == urap_pkg::ADDR_ID_SEL;
  assign timeout_w = st_q == urap_pkg::ST_COLLECT && byte_cnt_q != 3'h0
                     && to_q == TO_LAST && !rx_valid_q;
  // request stays up and stable until the arbiter grants it
  assign arb_req = {st_q == urap_pkg::ST_ACCESS && !local_w,
                    dg_q}; // flag, address and payload as received
  assign chip_id_selector = sel_q;

  // local read data: selector or the id word it picks
  logic [31:0] local_rd_w;
  assign local_rd_w = (dg_q.addr == urap_pkg::ADDR_ID_SEL) ? sel_q
                      : chip_id_value;

  // inactivity counter, restarted by every received byte
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      to_q <= 26'h0000000;
    end else if (rx_valid_q || byte_cnt_q == 3'h0) begin
      to_q <= 26'h0000000;
    end else if (to_q != TO_LAST) begin
      to_q <= to_q + 26'h0000001;
    end
  end

  // protocol handler
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= urap_pkg::ST_COLLECT;
      dg_q <= '0;
      resp_q <= '0;
      byte_cnt_q <= 3'h0;
      tx_idx_q <= 3'h0;
      sel_q <= urap_pkg::ID_SEL_RESET;
    end else begin
      unique case (st_q)
        urap_pkg::ST_COLLECT: begin
          if (rx_valid_q) begin
            dg_q <= {dg_q[31:0], rx_sh_q}; // first byte ends on top
            if (byte_cnt_q == urap_pkg::LAST_BYTE_IDX) begin
              byte_cnt_q <= 3'h0;
              st_q <= urap_pkg::ST_ACCESS;
            end else begin
              byte_cnt_q <= byte_cnt_q + 3'h1;
            end
          end else if (timeout_w) begin
            byte_cnt_q <= 3'h0; // partial command dropped
          end
        end
        urap_pkg::ST_ACCESS: begin
          tx_idx_q <= 3'h0;
          if (local_w) begin
            st_q <= urap_pkg::ST_RESPOND;
            if (dg_q.write_not_read_flag) begin
              resp_q <= dg_q;
              if (dg_q.addr == urap_pkg::ADDR_ID_SEL) begin
                sel_q <= dg_q.data;
              end
            end else begin
              resp_q <= {1'b0, dg_q.addr, local_rd_w};
            end
          end else if (arb_gnt) begin
            if (dg_q.write_not_read_flag) begin
              resp_q <= dg_q;
              st_q <= urap_pkg::ST_RESPOND;
            end else begin
              st_q <= urap_pkg::ST_WAIT_RD;
            end
          end
        end
        urap_pkg::ST_WAIT_RD: begin
          if (arb_rvalid) begin
            resp_q <= {1'b0, dg_q.addr, arb_rdata};
            st_q <= urap_pkg::ST_RESPOND;
          end
        end
        urap_pkg::ST_RESPOND: begin
          if (tx_load_w) begin
            resp_q <= {resp_q[31:0], 8'h00}; // msb byte first
            tx_idx_q <= tx_idx_q + 3'h1;
          end else if (!tx_busy_q && tx_idx_q == urap_pkg::DGRAM_BYTES) begin
            st_q <= urap_pkg::ST_COLLECT;
          end
        end
      endcase
    end
  end

  // checks
  property p_start_bit;
    @(posedge core_clk) disable iff (!rst_b)
    tx_load_w |=> !reg_port_serial_out && tx_busy_q;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start");

  property p_char_len;
    @(posedge core_clk) disable iff (!rst_b)
    $fell(tx_busy_q) |-> $past(tx_bit_q) == urap_pkg::STOP_BIT_IDX
                         && reg_port_serial_out;
  endproperty
  a_char_len: assert property (p_char_len) else $error("bad frame");

  property p_rate_hold;
    @(posedge core_clk) disable iff (!rst_b)
    rx_busy_q || tx_busy_q |=> $stable(rate_q);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate moved");

  property p_five_bytes;
    @(posedge core_clk) disable iff (!rst_b)
    $rose(st_q == urap_pkg::ST_ACCESS) |->
      $past(byte_cnt_q) == urap_pkg::LAST_BYTE_IDX && $past(rx_valid_q);
  endproperty
  a_five_bytes: assert property (p_five_bytes) else $error("short");

  property p_timeout;
    @(posedge core_clk) disable iff (!rst_b)
    timeout_w |=> byte_cnt_q == 3'h0 && st_q == urap_pkg::ST_COLLECT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no timeout");

  property p_req_hold;
    @(posedge core_clk) disable iff (!rst_b)
    arb_req.valid && !arb_gnt |=> arb_req.valid && $stable(arb_req);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req dropped");

  sequence s_resp_start;
    $rose(st_q == urap_pkg::ST_RESPOND);
  endsequence
  property p_write_echo;
    @(posedge core_clk) disable iff (!rst_b)
    s_resp_start and dg_q.write_not_read_flag |-> resp_q == dg_q;
  endproperty
  a_write_echo: assert property (p_write_echo) else $error("bad echo");

  property p_read_head;
    @(posedge core_clk) disable iff (!rst_b)
    s_resp_start and !dg_q.write_not_read_flag |->
      resp_q[39:32] == {1'b0, dg_q.addr};
  endproperty
  a_read_head: assert property (p_read_head) else $error("bad head");

  property p_sel_write;
    @(posedge core_clk) disable iff (!rst_b)
    st_q == urap_pkg::ST_ACCESS && dg_q.write_not_read_flag
      && dg_q.addr == urap_pkg::ADDR_ID_SEL |=> sel_q == $past(dg_q.data);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("sel lost");

  property p_back_idle;
    @(posedge core_clk) disable iff (!rst_b)
    st_q == urap_pkg::ST_RESPOND && !tx_busy_q
      && tx_idx_q == urap_pkg::DGRAM_BYTES |=> st_q == urap_pkg::ST_COLLECT
      && byte_cnt_q == 3'h0;
  endproperty
  a_back_idle: assert property (p_back_idle) else $error("not idle");
endmodule : urap_top
`default_nettype wire

// [dv/urap_host.sv]
// serial host and register arbiter standing behind the port
`default_nettype none
module urap_host (
  // clock and bit period
  input wire logic core_clk,
  input wire logic [12:0] bit_div,
  // serial line
  input wire logic reg_port_serial_out,
  output logic reg_port_serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rxq[$];
  int frame_err = 0;
  initial reg_port_serial_in = 1'b1; // idle high between commands
  // start bit, data lsb first, stop bit, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      reg_port_serial_in <= f[i];
      repeat (bit_div) @(posedge core_clk);
    end
  endtask : send_byte
  // mid-bit sampling, so a period off by a few counts still decodes
  always begin : rx
    logic [7:0] b;
    @(negedge reg_port_serial_out);
    repeat (bit_div / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_div) @(posedge core_clk);
      b[i] = reg_port_serial_out;
    end
    repeat (bit_div) @(posedge core_clk);
    if (reg_port_serial_out !== 1'b1) frame_err++;
    rxq.push_back(b);
  end
endmodule : urap_host

module urap_arb (
  // clock
  input wire logic core_clk,
  // request and answer
  input wire urap_pkg::urap_req_type arb_req,
  output logic arb_gnt,
  output logic arb_rvalid,
  output logic [31:0] arb_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem[128];
  logic [6:0] rd_a;
  int cnt = 0;
  int rd_n = 0;
  initial begin
    arb_gnt = 1'b0;
    arb_rvalid = 1'b0;
    arb_rdata = 32'h0;
    foreach (mem[i]) mem[i] = 32'hA5A5_0000 | i;
  end
  // random grant wait; data bus toggles while no word is valid
  always @(posedge core_clk) begin
    arb_gnt <= 1'b0;
    arb_rvalid <= 1'b0;
    arb_rdata <= ~arb_rdata;
    if (arb_req.valid === 1'b1 && !arb_gnt) begin
      if (cnt == 0) begin
        arb_gnt <= 1'b1;
        if (arb_req.we) mem[arb_req.addr] <= arb_req.wdata;
        else rd_n = 2 + $urandom % 3;
        rd_a = arb_req.addr;
        cnt = $urandom % 5;
      end else cnt--;
    end
    if (rd_n > 0) begin
      rd_n--;
      if (rd_n == 0) begin
        arb_rvalid <= 1'b1;
        arb_rdata <= mem[rd_a];
      end
    end
  end
endmodule : urap_arb
`default_nettype wire

// [dv/urap_top_bench.sv]
// self-checking bench of the serial register access port
`default_nettype none
module urap_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV_S = 16;
  localparam int TMO = 6000;
  localparam logic [31:0] ID_SALT = 32'h1357_9BDF; // arbitrary id pattern
  localparam logic [12:0] DIVS[4] = '{13'(DIV_S), urap_pkg::DIV_MID,
    urap_pkg::DIV_FAST, urap_pkg::DIV_MAX};
  localparam int CNTS[4] = '{6, 1, 2, 4};
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] baud_sel = 2'h0;
  logic [12:0] bit_div = 13'h10;
  logic [31:0] chip_id_value = 32'h0;
  logic ser_in, ser_out, arb_gnt, arb_rvalid;
  logic [31:0] arb_rdata, sel_out, sel_m;
  logic [31:0] ref_m[128];
  urap_pkg::urap_req_type arb_req;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  urap_top #(.DIV_DEFAULT_CYC(DIV_S), .TIMEOUT_CYC(TMO)) urap_top_inst (
    .core_clk(core_clk), .rst_b(rst_b), .baud_sel(baud_sel),
    .reg_port_serial_in(ser_in), .reg_port_serial_out(ser_out),
    .arb_req(arb_req), .arb_gnt(arb_gnt), .arb_rvalid(arb_rvalid),
    .arb_rdata(arb_rdata), .chip_id_selector(sel_out),
    .chip_id_value(chip_id_value));
  urap_host urap_host_inst (.core_clk(core_clk), .bit_div(bit_div),
    .reg_port_serial_out(ser_out), .reg_port_serial_in(ser_in));
  urap_arb urap_arb_inst (.core_clk(core_clk), .arb_req(arb_req),
    .arb_gnt(arb_gnt), .arb_rvalid(arb_rvalid), .arb_rdata(arb_rdata));
  initial forever #10 core_clk = ~core_clk;
  // the chip answers each selector with a word of its own
  always @(posedge core_clk) chip_id_value <= sel_out ^ ID_SALT;
  // hang guard, sized above the slowest rate's traffic
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 99000) begin
      num_errors++;
      results();
    end
  end
  task automatic results;
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // expected answer; local addresses never reach the arbiter
  function automatic logic [39:0] model(input logic [7:0] b0,
      input logic [31:0] d);
    logic [6:0] a;
    a = b0[6:0];
    if (b0[7]) begin
      if (a == 7'h01) sel_m = d;
      else if (a != 7'h00) ref_m[a] = d;
      return {b0, d};
    end
    if (a == 7'h00) return {b0, sel_m ^ ID_SALT};
    if (a == 7'h01) return {b0, sel_m};
    return {b0, ref_m[a]};
  endfunction : model
  // one command msb first, optional pause after byte one, then the answer
  task automatic cmd(input logic [7:0] b0, input logic [31:0] d,
      input int gap);
    logic [39:0] w, exp, got;
    int t;
    w = {b0, d};
    exp = model(b0, d);
    chk(40'(urap_host_inst.rxq.size()), 40'h0);
    for (int i = 4; i >= 0; i--) begin
      urap_host_inst.send_byte(w[i*8+:8]);
      if (i == 4) repeat (gap) @(posedge core_clk);
    end
    t = 0;
    while (urap_host_inst.rxq.size() < 5 && t < 60000) begin
      @(posedge core_clk);
      t++;
    end
    if (t == 60000) begin
      num_errors++;
      $display("MISMATCH %0t no response", $time);
    end
    for (int i = 4; i >= 0; i--) got[i*8+:8] = urap_host_inst.rxq.pop_front();
    chk(got, exp);
    chk({8'h0, sel_out}, {8'h0, sel_m});
    repeat (bit_div + 4) @(posedge core_clk);
  endtask : cmd
  initial begin
    void'($urandom(55248));
    sel_m = 32'h0;
    foreach (ref_m[i]) ref_m[i] = 32'hA5A5_0000 | i;
    repeat (8) @(posedge core_clk);
    chk({6'h0, ser_out, arb_req.valid, sel_out}, 40'h2_0000_0000);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmd(8'h81, 32'h0000_0005, 0);
    cmd(8'h00, 32'hFFFF_FFFF, 0);
    cmd(8'h01, 32'h1234_5678, 0);
    cmd(8'h80, 32'hDEAD_BEEF, 0);
    // a stale partial command must be dropped after the pause
    urap_host_inst.send_byte(8'h85);
    urap_host_inst.send_byte(8'h11);
    repeat (TMO + 200) @(posedge core_clk);
    cmd(8'h05, 32'h0, TMO - 20 * DIV_S);
    // every line rate, back-to-back random commands
    for (int r = 0; r < 4; r++) begin
      baud_sel <= 2'(r);
      bit_div <= DIVS[r];
      repeat (4) @(posedge core_clk);
      for (int n = 0; n < CNTS[r]; n++) cmd(8'($urandom), $urandom, 0);
    end
    chk(40'(urap_host_inst.frame_err), 40'h0);
    results();
  end
endmodule : urap_top_bench
`default_nettype wire
